// ---- hdl/rsu_core.sv ----
// Remote image upgrade engine: shift/update/control/status registers and reload control
`timescale 1ns/1ps
module rsu_core
	import rsu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        nrst,
	input  wire logic        upgrade_shift_clock,
	input  wire logic        upgrade_serial_in,
	input  wire logic        shift_or_load_select,
	input  wire logic        capture_or_update_select,
	input  wire logic        capture_source_select,
	input  wire logic        fabric_reload_strobe,
	input  wire logic        watchdog_kick,
	input  wire logic        error_status_pin_n,
	input  wire logic        external_reload_pin_n,
	input  wire logic        remote_mode_pin,
	input  wire logic        parallel_memory_boot,
	input  wire logic        set_factory_boot_instr,
	input  wire logic [23:0] factory_boot_value,
	input  wire logic        crc_error,
	input  wire logic        load_done,
	input  wire logic        load_error,
	input  wire logic        early_done_fault,
	output logic             upgrade_serial_out,
	output logic             load_start,
	output logic      [23:0] load_address,
	output logic             image_is_factory,
	output logic             startup_osc_select,
	output logic             watchdog_running,
	output logic             reconfig_busy
);

	// Returns only the highest set cause bit
	function automatic logic [4:0] top_cause(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 5; i++) begin
			if (c[i]) begin
				r = 5'h01 << i;
			end
		end
		return r;
	endfunction : top_cause

	// Boot page to byte address
	function automatic logic [23:0] page_to_addr(input logic [21:0] page);
		return {page, PAGE_LOW_BITS};
	endfunction : page_to_addr

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_lvl;
	logic [PIN_W-1:0] pins_rise;
	logic [PIN_W-1:0] pins_fall;

	logic             straps_taken_reg;
	logic             remote_reg;
	logic             parallel_reg;
	logic [23:0]      factory_addr_reg;
	logic [SR_W-1:0]  shift_reg;
	rsu_ctrl_t        update_reg;
	rsu_ctrl_t        control_reg;
	rsu_status_t      status_reg;
	rsu_state_t       state_reg;
	logic             factory_reg;
	logic [23:0]      cur_addr_reg;
	logic             load_start_reg;
	logic [23:0]      load_addr_reg;
	logic [7:0]       fabric_cnt_reg;
	logic             fabric_fired_reg;
	logic             fabric_pulse;
	logic [28:0]      wd_cnt_reg;
	logic             wd_expired_reg;
	logic             wd_active;
	logic [28:0]      wd_limit;
	logic [4:0]       cause_raw;
	logic [4:0]       cause;
	logic             trigger;
	logic             fabric_only;
	logic             to_factory;
	logic [1:0]       ms_code;
	logic [23:0]      factory_addr;
	rsu_ctrl_t        control_next;
	logic [23:0]      reload_addr;

	assign pins_raw = {parallel_memory_boot, remote_mode_pin, external_reload_pin_n,
		error_status_pin_n, watchdog_kick, fabric_reload_strobe, capture_source_select,
		capture_or_update_select, shift_or_load_select, upgrade_serial_in,
		upgrade_shift_clock};

	rsu_sync #(
		.W(PIN_W)
	) u_sync (
		.clk   (clk),
		.ce    (ce),
		.nrst  (nrst),
		.pin_in(pins_raw),
		.level (pins_lvl),
		.rise  (pins_rise),
		.fall  (pins_fall)
	);

	// Straps are caught once, after reset release, from synchronised levels
	// The synchroniser fills during reset, so the first edge sees settled straps
	always_ff @(posedge clk) begin
		if (!nrst) begin
			straps_taken_reg <= 1'b0;
			remote_reg       <= 1'b0;
			parallel_reg     <= 1'b0;
		end else if (ce && !straps_taken_reg) begin
			straps_taken_reg <= 1'b1;
			remote_reg       <= pins_lvl[PIN_REMOTE];
			parallel_reg     <= pins_lvl[PIN_PAR];
		end
	end

	// Factory address override from boundary scan, parallel scheme only
	always_ff @(posedge clk) begin
		if (!nrst) begin
			factory_addr_reg <= PARALLEL_FACTORY_ADDR;
		end else if (ce && set_factory_boot_instr) begin
			factory_addr_reg <= factory_boot_value;
		end
	end

	assign factory_addr = parallel_reg ? factory_addr_reg : SERIAL_FACTORY_ADDR;

	// Shift register works on sampled shift-clock rising edges.
	// Sampling limits usable shift clock well below its 40 MHz ceiling.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			shift_reg <= '0;
		end else if (ce && pins_rise[PIN_SCLK]) begin
			if (pins_lvl[PIN_SHIFT]) begin
				shift_reg <= {pins_lvl[PIN_SDIN], shift_reg[SR_W-1:1]};
			end else if (pins_lvl[PIN_CAPT]) begin
				if (!pins_lvl[PIN_SRC]) begin
					shift_reg <= {7'h00, status_reg};
				end else if (factory_reg) begin
					shift_reg <= update_reg;
				end else begin
					shift_reg <= control_reg;
				end
			end
		end
	end

	assign upgrade_serial_out = shift_reg[0];

	// Update register: factory image, remote mode, update operation only
	// A refused write gives no sign; the factory reads back to confirm
	always_ff @(posedge clk) begin
		if (!nrst) begin
			update_reg <= CTRL_RESET;
		end else if (ce && pins_rise[PIN_SCLK] && !pins_lvl[PIN_SHIFT] && !pins_lvl[PIN_CAPT]
				&& factory_reg && remote_reg && state_reg == ST_RUN) begin
			update_reg <= shift_reg;
		end
	end

	// Fabric reload must stay high long enough to count as intended
	// One reload per strobe, however long it is held
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fabric_cnt_reg   <= 8'h00;
			fabric_fired_reg <= 1'b0;
		end else if (ce) begin
			if (!pins_lvl[PIN_FABRIC]) begin
				fabric_cnt_reg   <= 8'h00;
				fabric_fired_reg <= 1'b0;
			end else if (fabric_cnt_reg != 8'(RELOAD_MIN_CYC)) begin
				fabric_cnt_reg <= fabric_cnt_reg + 8'h01;
			end else begin
				fabric_fired_reg <= 1'b1;
			end
		end
	end

	assign fabric_pulse = pins_lvl[PIN_FABRIC] && !fabric_fired_reg
		&& fabric_cnt_reg == 8'(RELOAD_MIN_CYC);

	// User watchdog: applications only, restarted by each kick
	// Expiry flag lasts one cycle; the reload it causes restarts the count
	assign wd_active = remote_reg && !factory_reg && state_reg == ST_RUN
		&& control_reg.watchdog_enable_bit;
	assign wd_limit  = {control_reg.watchdog_timeout_field, WD_LOW_PATTERN};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wd_cnt_reg     <= 29'h0000_0000;
			wd_expired_reg <= 1'b0;
		end else if (ce) begin
			wd_expired_reg <= 1'b0;
			if (!wd_active || pins_rise[PIN_KICK] || trigger) begin
				wd_cnt_reg <= 29'h0000_0000;
			end else if (wd_cnt_reg == wd_limit) begin
				wd_expired_reg <= 1'b1;
				wd_cnt_reg     <= 29'h0000_0000;
			end else begin
				wd_cnt_reg <= wd_cnt_reg + 29'h0000_0001;
			end
		end
	end

	assign watchdog_running = wd_active;

	// Reconfiguration causes, highest bit wins a tie
	// Nothing is taken before the power-up load has been started
	always_comb begin
		cause_raw = 5'h00;
		if (state_reg != ST_POWER) begin
			if (pins_fall[PIN_EXT_N]) begin
				cause_raw = cause_raw | CAUSE_EXT;
			end
			if (crc_error || (state_reg == ST_LOAD && (load_error
					|| (load_done && control_reg.early_done_check_bit
					&& early_done_fault)))) begin
				cause_raw = cause_raw | CAUSE_CRC;
			end
			if (pins_fall[PIN_ERR_N]) begin
				cause_raw = cause_raw | CAUSE_ERRPIN;
			end
			if (wd_expired_reg) begin
				cause_raw = cause_raw | CAUSE_WDOG;
			end
			if (fabric_pulse && state_reg == ST_RUN) begin
				cause_raw = cause_raw | CAUSE_FABRIC;
			end
		end
	end

	assign cause       = top_cause(cause_raw);
	assign trigger     = cause != 5'h00;
	assign fabric_only = cause == CAUSE_FABRIC;
	// Errors always fall back; a fabric reload from an application returns to factory
	assign to_factory  = !remote_reg || !fabric_only || !factory_reg;

	always_comb begin
		if (fabric_only) begin
			control_next = update_reg;
		end else begin
			control_next = CTRL_RESET;
		end
	end

	// Any sector boundary is legal; the page is not range-checked
	// A fabric reload from an application still lands on the factory image
	assign reload_addr = to_factory ? factory_addr
		: page_to_addr(control_next.boot_page_field);

	// State code as seen when the trigger lands
	always_comb begin
		case (state_reg)
			ST_RUN:  ms_code = factory_reg ? MS_FACTORY : MS_APP;
			ST_LOAD: ms_code = MS_LOADING;
			default: ms_code = MS_FACTORY;
		endcase
	end

	// Master sequence: power-up load, then run and reload on triggers.
	// Control and status sit on the main clock, standing in for the oscillator.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg      <= ST_POWER;
			factory_reg    <= 1'b1;
			control_reg    <= CTRL_RESET;
			status_reg     <= STAT_RESET;
			cur_addr_reg   <= 24'h000000;
			load_start_reg <= 1'b0;
			load_addr_reg  <= 24'h000000;
		end else if (ce) begin
			load_start_reg <= 1'b0;
			case (state_reg)
				ST_POWER: begin
					if (straps_taken_reg) begin
						control_reg                 <= CTRL_RESET;
						control_reg.boot_page_field <= factory_addr[23:2];
						factory_reg                 <= 1'b1;
						cur_addr_reg                <= factory_addr;
						load_addr_reg               <= factory_addr;
						load_start_reg              <= 1'b1;
						state_reg                   <= ST_LOAD;
					end
				end
				ST_LOAD, ST_RUN: begin
					if (trigger) begin
						status_reg.rsv          <= 1'b0;
						status_reg.cause        <= cause;
						status_reg.master_state <= ms_code;
						// Address of the image being left, not the next one
						status_reg.boot_address <= cur_addr_reg;
						control_reg             <= control_next;
						factory_reg             <= to_factory;
						cur_addr_reg            <= reload_addr;
						load_addr_reg           <= reload_addr;
						load_start_reg          <= 1'b1;
						state_reg               <= ST_LOAD;
					end else if (state_reg == ST_LOAD && load_done) begin
						state_reg <= ST_RUN;
					end
				end
				default: begin
					state_reg <= ST_POWER;
				end
			endcase
		end
	end

	assign load_start         = load_start_reg;
	assign load_address       = load_addr_reg;
	assign image_is_factory   = factory_reg;
	assign startup_osc_select = control_reg.osc_startup_bit;
	assign reconfig_busy      = state_reg != ST_RUN;

endmodule : rsu_core

// ---- hdl/rsu_pkg.sv ----
// Constants, field layouts and carrier types for the remote image upgrade block
package rsu_pkg;

	// Register widths
	localparam int CTRL_W = 39;
	localparam int STAT_W = 32;
	localparam int SR_W   = 39;

	// Control register field positions
	localparam int CTRL_TIMER_LSB = 0;
	localparam int CTRL_PAGE_LSB  = 12;
	localparam int CTRL_RSV1_POS  = 34;
	localparam int CTRL_WDEN_POS  = 35;
	localparam int CTRL_OSC_POS   = 36;
	localparam int CTRL_EARLY_POS = 37;
	localparam int CTRL_RSV2_POS  = 38;

	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RESET  = 39'h00_0000_0000;
	localparam logic [STAT_W-1:0] STAT_RESET  = 32'h0000_0000;
	localparam logic [23:0]       SERIAL_FACTORY_ADDR   = 24'h000000;
	localparam logic [23:0]       PARALLEL_FACTORY_ADDR = 24'h010000;

	// Boot address and watchdog count composition
	localparam logic [1:0]  PAGE_LOW_BITS  = 2'h0;
	localparam logic [16:0] WD_LOW_PATTERN = 17'h00008;

	// Status register: one-hot cause, higher bit wins a tie
	localparam logic [4:0] CAUSE_EXT    = 5'h10;
	localparam logic [4:0] CAUSE_CRC    = 5'h08;
	localparam logic [4:0] CAUSE_ERRPIN = 5'h04;
	localparam logic [4:0] CAUSE_WDOG   = 5'h02;
	localparam logic [4:0] CAUSE_FABRIC = 5'h01;
	localparam logic [1:0] MS_FACTORY   = 2'h0;
	localparam logic [1:0] MS_APP       = 2'h1;
	localparam logic [1:0] MS_LOADING   = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int RELOAD_MIN_NS   = 250;
	localparam int RELOAD_MIN_CYC  = (RELOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHIFT_CLK_MAX_MHZ = 40;

	// Synchronised pin vector positions
	localparam int PIN_SCLK   = 0;
	localparam int PIN_SDIN   = 1;
	localparam int PIN_SHIFT  = 2;
	localparam int PIN_CAPT   = 3;
	localparam int PIN_SRC    = 4;
	localparam int PIN_FABRIC = 5;
	localparam int PIN_KICK   = 6;
	localparam int PIN_ERR_N  = 7;
	localparam int PIN_EXT_N  = 8;
	localparam int PIN_REMOTE = 9;
	localparam int PIN_PAR    = 10;
	localparam int PIN_W      = 11;

	typedef struct packed {
		logic        rsv2;
		logic        early_done_check_bit;
		logic        osc_startup_bit;
		logic        watchdog_enable_bit;
		logic        rsv1;
		logic [21:0] boot_page_field;
		logic [11:0] watchdog_timeout_field;
	} rsu_ctrl_t;

	typedef struct packed {
		logic        rsv;
		logic [4:0]  cause;
		logic [1:0]  master_state;
		logic [23:0] boot_address;
	} rsu_status_t;

	typedef enum logic [1:0] {
		ST_POWER,
		ST_LOAD,
		ST_RUN
	} rsu_state_t;

endpackage : rsu_pkg

// ---- hdl/rsu_sync.sv ----
// Two-stage pin synchroniser with edge detection on the settled level
`timescale 1ns/1ps
module rsu_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         ce,
	input  wire logic         nrst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;
	logic [W-1:0] stage3_reg;

	// Edges look only at stages two and three, never the first stage.
	// Not reset: the stages fill during reset, so straps are settled at release.
	always_ff @(posedge clk) begin
		if (ce) begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	assign level = stage2_reg;
	// Edges held off while in reset
	assign rise  = nrst ? (stage2_reg & ~stage3_reg) : '0;
	assign fall  = nrst ? (~stage2_reg & stage3_reg) : '0;

endmodule : rsu_sync

// ---- tb/rsu_core_properties.sv ----
// Port-level checks for the remote image upgrade core
`timescale 1ns/1ps
module rsu_core_properties
	import rsu_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        upgrade_shift_clock,
	input wire logic        error_status_pin_n,
	input wire logic        external_reload_pin_n,
	input wire logic        parallel_memory_boot,
	input wire logic        crc_error,
	input wire logic        load_done,
	input wire logic        upgrade_serial_out,
	input wire logic        load_start,
	input wire logic [23:0] load_address,
	input wire logic        image_is_factory,
	input wire logic        startup_osc_select,
	input wire logic        watchdog_running,
	input wire logic        reconfig_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_rel;
		nrst && !$past(nrst);
	endsequence
	// Pin faults pass two sync flops before they are taken
	sequence s_to_factory;
		##[2:6] (load_start && image_is_factory);
	endsequence

	AST_REL_SERIAL: assert property (s_rel ##0 !parallel_memory_boot |->
		##[1:3] (load_start && load_address == SERIAL_FACTORY_ADDR))
		else $error("serial power-up address wrong");
	AST_REL_PARALLEL: assert property (s_rel ##0 parallel_memory_boot |->
		##[1:3] (load_start && load_address == PARALLEL_FACTORY_ADDR))
		else $error("parallel power-up address wrong");
	AST_CRC_CLEAR: assert property (crc_error && !reconfig_busy && !parallel_memory_boot |->
		##[1:2] (load_start && load_address == 24'h000000) ##1 !startup_osc_select)
		else $error("crc error did not reload cleared factory");
	AST_PAGE_LOW: assert property (load_start |-> load_address[1:0] == PAGE_LOW_BITS)
		else $error("boot address low bits not zero");
	AST_DONE_RUN: assert property (load_done && reconfig_busy && !load_start |->
		##[1:2] !reconfig_busy)
		else $error("load done did not end loading");
	AST_ERRPIN: assert property ($fell(error_status_pin_n) && !reconfig_busy |-> s_to_factory)
		else $error("error pin did not reload factory");
	AST_EXTPIN: assert property ($fell(external_reload_pin_n) && !reconfig_busy |-> s_to_factory)
		else $error("external reload did not reload factory");
	AST_WDOG_APP: assert property (watchdog_running |-> !image_is_factory)
		else $error("watchdog running in factory image");
	AST_SOUT_HOLD: assert property (!upgrade_shift_clock [*6] |-> $stable(upgrade_serial_out))
		else $error("serial out moved without shift clock");
endmodule : rsu_core_properties

bind rsu_core rsu_core_properties rsu_core_properties_inst (.clk, .nrst, .upgrade_shift_clock,
	.error_status_pin_n, .external_reload_pin_n, .parallel_memory_boot, .crc_error, .load_done,
	.upgrade_serial_out, .load_start, .load_address, .image_is_factory, .startup_osc_select,
	.watchdog_running, .reconfig_busy);

// ---- tb/rsu_fabric_model.sv ----
// Fabric user logic model driving the shift link, reload strobe and kicks
`timescale 1ns/1ps
module rsu_fabric_model
	import rsu_pkg::*;
(
	input  wire logic upgrade_serial_out,
	output logic      upgrade_shift_clock,
	output logic      upgrade_serial_in,
	output logic      shift_or_load_select,
	output logic      capture_or_update_select,
	output logic      capture_source_select,
	output logic      fabric_reload_strobe,
	output logic      watchdog_kick
);
	logic kick_en;
	initial begin
		{upgrade_shift_clock, upgrade_serial_in, shift_or_load_select} = 3'h0;
		{capture_or_update_select, capture_source_select} = 2'h0;
		{fabric_reload_strobe, watchdog_kick, kick_en} = 3'h0;
	end
	// App keeps its watchdog alive while enabled
	always #300 if (kick_en) watchdog_kick = ~watchdog_kick;
	// Clock idles low; 160 ns period keeps it under 40 MHz
	task automatic par_op(input logic capt, input logic src);
		shift_or_load_select = 1'b0;
		capture_or_update_select = capt;
		capture_source_select = src;
		#80 upgrade_shift_clock = 1'b1;
		#80 upgrade_shift_clock = 1'b0;
	endtask : par_op
	// Bit 0 leaves first while new data enters at the top
	task automatic xfer(input rsu_ctrl_t din, output logic [SR_W-1:0] dout);
		shift_or_load_select = 1'b1;
		for (int i = 0; i < SR_W; i++) begin
			upgrade_serial_in = din[i];
			#40 dout[i] = upgrade_serial_out;
			#40 upgrade_shift_clock = 1'b1;
			#80 upgrade_shift_clock = 1'b0;
		end
		upgrade_serial_in = ~upgrade_serial_in;
	endtask : xfer
	// Next boot page and watchdog choice go through update
	task automatic write_upd(input rsu_ctrl_t w);
		logic [SR_W-1:0] d;
		xfer(w, d);
		par_op(1'b0, 1'b0);
	endtask : write_upd
	// Held well over the minimum so the sync sees it
	task automatic reload();
		fabric_reload_strobe = 1'b1;
		#350 fabric_reload_strobe = 1'b0;
	endtask : reload
endmodule : rsu_fabric_model

// ---- tb/test_rsu_core.sv ----
// Self-checking bench for the remote image upgrade core
`timescale 1ns/1ps
module test_rsu_core;
	import rsu_pkg::*;
	logic clk, ce, nrst, upgrade_shift_clock, upgrade_serial_in, shift_or_load_select;
	logic capture_or_update_select, capture_source_select, fabric_reload_strobe, watchdog_kick;
	logic error_status_pin_n, external_reload_pin_n, remote_mode_pin, parallel_memory_boot;
	logic set_factory_boot_instr, crc_error, load_done, load_error, early_done_fault;
	logic upgrade_serial_out, load_start, image_is_factory, startup_osc_select;
	logic watchdog_running, reconfig_busy;
	logic [23:0]     factory_boot_value, load_address, fa;
	logic [21:0]     p1, p2;
	logic [31:0]     rng;
	logic [SR_W-1:0] sr;
	int              bad_count, samples_checked, cyc;

	rsu_core rsu_core_inst (.clk, .ce, .nrst, .upgrade_shift_clock, .upgrade_serial_in,
		.shift_or_load_select, .capture_or_update_select, .capture_source_select,
		.fabric_reload_strobe, .watchdog_kick, .error_status_pin_n, .external_reload_pin_n,
		.remote_mode_pin, .parallel_memory_boot, .set_factory_boot_instr, .factory_boot_value,
		.crc_error, .load_done, .load_error, .early_done_fault, .upgrade_serial_out, .load_start,
		.load_address, .image_is_factory, .startup_osc_select, .watchdog_running, .reconfig_busy);
	rsu_fabric_model rsu_fabric_model_inst (.upgrade_serial_out, .upgrade_shift_clock,
		.upgrade_serial_in, .shift_or_load_select, .capture_or_update_select,
		.capture_source_select, .fabric_reload_strobe, .watchdog_kick);

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			test_done();
		end
	end

	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : nxt
	function automatic rsu_ctrl_t mk(input logic osc, input logic wd, input logic [21:0] pg);
		rsu_ctrl_t c;
		c = '0;
		c.osc_startup_bit = osc;
		c.watchdog_enable_bit = wd;
		c.boot_page_field = pg;
		return c;
	endfunction : mk
	task automatic chk(input logic [SR_W-1:0] got, input logic [SR_W-1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Waits for a load, checks it, then reports it finished
	task automatic boot(input logic [23:0] addr, input logic fac);
		for (int i = 0; i < 200 && load_start !== 1'b1; i++) @(negedge clk);
		chk(load_start, 1'b1);
		chk(load_address, addr);
		chk(image_is_factory, fac);
		repeat (12) @(negedge clk);
		load_done = 1'b1;
		@(negedge clk) load_done = 1'b0;
		repeat (3) @(negedge clk);
		chk(reconfig_busy, 1'b0);
	endtask : boot
	task automatic read(input logic src);
		rsu_fabric_model_inst.par_op(1'b1, src);
		rsu_fabric_model_inst.xfer('0, sr);
	endtask : read
	task automatic pulse_crc();
		@(negedge clk) crc_error = 1'b1;
		@(negedge clk) crc_error = 1'b0;
	endtask : pulse_crc
	task automatic test_done();
		$display("Checks %0d, errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	initial begin
		{clk, nrst, parallel_memory_boot, set_factory_boot_instr, crc_error} = 5'h00;
		{load_done, load_error, early_done_fault, ce, remote_mode_pin} = 5'h03;
		{error_status_pin_n, external_reload_pin_n} = 2'h3;
		factory_boot_value = 24'h000000;
		rng = 32'h0000001a;
		{bad_count, samples_checked, cyc} = '0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		boot(SERIAL_FACTORY_ADDR, 1'b1);
		p1 = 22'(nxt());
		rsu_fabric_model_inst.write_upd(mk(1'b1, 1'b0, p1));
		read(1'b1);
		chk(sr, mk(1'b1, 1'b0, p1));
		fork
			rsu_fabric_model_inst.reload();
			boot({p1, PAGE_LOW_BITS}, 1'b0);
		join
		chk({startup_osc_select, watchdog_running}, 2'h2);
		rsu_fabric_model_inst.kick_en = 1'b1;
		read(1'b1);
		chk(sr, mk(1'b1, 1'b0, p1));
		rsu_fabric_model_inst.write_upd(mk(1'b0, 1'b1, ~p1));
		rsu_fabric_model_inst.kick_en = 1'b0;
		pulse_crc();
		boot(SERIAL_FACTORY_ADDR, 1'b1);
		chk(startup_osc_select, 1'b0);
		read(1'b0);
		chk({sr[30:26], sr[23:0]}, {CAUSE_CRC, p1, PAGE_LOW_BITS});
		read(1'b1);
		chk(sr, mk(1'b1, 1'b0, p1));
		p2 = 22'(nxt());
		rsu_fabric_model_inst.write_upd(mk(1'b0, 1'b1, p2));
		fork
			rsu_fabric_model_inst.reload();
			boot({p2, PAGE_LOW_BITS}, 1'b0);
		join
		boot(SERIAL_FACTORY_ADDR, 1'b1);
		read(1'b0);
		chk(sr[30:26], CAUSE_WDOG);
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			if (k == 0)
				external_reload_pin_n = 1'b0;
			else
				error_status_pin_n = 1'b0;
			boot(SERIAL_FACTORY_ADDR, 1'b1);
			{error_status_pin_n, external_reload_pin_n} = 2'h3;
			read(1'b0);
			chk(sr[30:26], (k == 0) ? CAUSE_EXT : CAUSE_ERRPIN);
		end
		nrst = 1'b0;
		parallel_memory_boot = 1'b1;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		boot(PARALLEL_FACTORY_ADDR, 1'b1);
		fa = 24'(nxt() & 32'h00fffffc);
		factory_boot_value = fa;
		set_factory_boot_instr = 1'b1;
		@(negedge clk) set_factory_boot_instr = 1'b0;
		pulse_crc();
		boot(fa, 1'b1);
		pulse_crc();
		repeat (4) @(negedge clk);
		load_error = 1'b1;
		@(negedge clk) load_error = 1'b0;
		boot(fa, 1'b1);
		read(1'b0);
		chk(sr[30:24], {CAUSE_CRC, MS_LOADING});
		test_done();
	end
endmodule : test_rsu_core
